//--- logic/dsp_alu.sv
// Operation
// (RULE1) Ops need prefix 111110; true-conditional runs only when flag is one.
// (RULE2) False-conditional runs only when flag is zero, else destination unchanged.
// (RULE3) Decrement subtracts one from X bits 39:16 or Y bits 31:16.
// (RULE4) Clear writes zero to destination; suffixes 10 and 11 are conditional.
// (RULE5) Arithmetic immediate shift: left for non-negative, right by magnitude otherwise.
// (RULE6) Logical immediate shift: left for non-negative, right for negative immediate.
// (RULE7) Store from accumulator copies high or low into destination, flag untouched.
// (RULE8) Load to accumulator copies destination register into high or low, flag untouched.
// (RULE9) Add with carry sums sources plus flag, carry out goes to flag.
// (RULE10) Subtract with borrow subtracts second and flag, borrow goes to flag.
// (RULE11) Compare subtracts only to update the flag, no destination write.
// (RULE12) Absolute value negates a negative source, else nothing happens.
// (RULE13) Round adds 0x8000 and clears the low half of the result.
// (RULE14) Carry mode: carry or shifted-out bit to flag, logical ops clear.
// (RULE15) Negative mode: arithmetic results copy MSB including guard bits.
// (RULE16) Negative mode: logical results copy MSB excluding guard bits.
// (RULE17) Zero mode: flag set when result is all zeros.
// (RULE18) Overflow mode: flag set on out-of-range arithmetic result, logical clears.
// (RULE19) Greater-than mode: flag is not of zero or negative xor overflow.
// (RULE20) Greater-or-equal mode: inverse negative without overflow, negative with overflow.
// (RULE21) Flag gating never suppresses the parallel data transfer field.
// (RULE22) Only unconditional ALU and shift ops update the flag.
// (RULE23) Mode codes 110 and 111 leave the flag unchanged.
`default_nettype none
`include "dsp_alu_regs.svh"
module dsp_alu
  import dsp_alu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             xfer_valid,
  output logic      [9:0]  xfer_field
);

  logic [39:0] rf_r [8];
  logic [31:0] accum_high_reg_r;
  logic [31:0] accum_low_reg_r;
  logic        condition_flag_r;
  logic [2:0]  mode_r;
  logic [31:0] instr_r;
  logic        exec_r;
  logic        ill_r;
  logic        done_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        xfer_valid_r;
  logic [9:0]  xfer_field_r;

  function automatic logic [2:0] sx_index(input logic [1:0] c);
    unique case (c)
      2'b00: sx_index = 3'd4;
      2'b01: sx_index = 3'd5;
      2'b10: sx_index = 3'd0;
      2'b11: sx_index = 3'd1;
    endcase
  endfunction : sx_index

  function automatic logic [2:0] sy_index(input logic [1:0] c);
    unique case (c)
      2'b00: sy_index = 3'd6;
      2'b01: sy_index = 3'd7;
      2'b10: sy_index = 3'd2;
      2'b11: sy_index = 3'd3;
    endcase
  endfunction : sy_index

  function automatic logic [39:0] fit(input logic [2:0] idx, input logic [39:0] v);
    fit = (idx < 3'd2) ? v : {{8{v[31]}}, v[31:0]};
  endfunction : fit

  function automatic logic range_err(input logic [39:0] v);
    range_err = ~((&v[39:31]) | ~(|v[39:31]));
  endfunction : range_err

  function automatic logic [40:0] add41(input logic [39:0] a, input logic [39:0] b,
                                        input logic cin);
    add41 = {1'b0, a} + {1'b0, b} + {40'h0000000000, cin};
  endfunction : add41

  function automatic logic [40:0] sub41(input logic [39:0] a, input logic [39:0] b,
                                        input logic bin);
    sub41 = {1'b0, a} - {1'b0, b} - {40'h0000000000, bin};
  endfunction : sub41

  // Operation decode
  wire         pfx_ok   = (instr_r[`PFX_HI:`PFX_LO] == `PFX_CODE); // RULE1
  wire  [7:0]  opb      = instr_r[15:8];
  wire  [5:0]  grp      = opb[7:2];
  wire  [1:0]  cnd      = opb[1:0];
  wire  [4:0]  shf      = instr_r[15:11];
  wire  [6:0]  imm      = instr_r[10:4];
  wire         has_cnd  = (cnd != `CND_NONE);
  wire         is_uncnd = (cnd == `CND_ALWAYS);
  wire         go_cnd   = is_uncnd
                        | ((cnd == `CND_TRUE) & condition_flag_r)   // RULE1
                        | ((cnd == `CND_FALSE) & ~condition_flag_r); // RULE2
  wire         dec_x    = (grp == `GRP_DEC_X) & has_cnd;
  wire         dec_y    = (grp == `GRP_DEC_Y) & has_cnd;
  wire         clr_op   = (grp == `GRP_CLR) & has_cnd;
  wire         sts_h    = (grp == `GRP_STS_H) & has_cnd;
  wire         sts_l    = (grp == `GRP_STS_L) & has_cnd;
  wire         lds_h    = (grp == `GRP_LDS_H) & has_cnd;
  wire         lds_l    = (grp == `GRP_LDS_L) & has_cnd;
  wire         ash_op   = (shf == `SHF_ARITH);
  wire         lsh_op   = (shf == `SHF_LOGIC);
  wire         abs_x    = (opb == `OPB_ABS_X);
  wire         abs_y    = (opb == `OPB_ABS_Y);
  wire         rnd_x    = (opb == `OPB_RND_X);
  wire         rnd_y    = (opb == `OPB_RND_Y);

  op_t op;
  assign op = !pfx_ok                ? OP_NONE :
              (dec_x | dec_y)        ? OP_DEC  :
              clr_op                 ? OP_CLR  :
              ash_op                 ? OP_ASH  :
              lsh_op                 ? OP_LSH  :
              (sts_h | sts_l)        ? OP_STS  :
              (lds_h | lds_l)        ? OP_LDS  :
              (opb == `OPB_ADDC)     ? OP_ADDC :
              (opb == `OPB_SUBC)     ? OP_SUBC :
              (opb == `OPB_CMP)      ? OP_CMP  :
              (abs_x | abs_y)        ? OP_ABS  :
              (rnd_x | rnd_y)        ? OP_RND  : OP_NONE;

  // Operand selection
  wire  [2:0]  sx_idx   = sx_index(instr_r[7:6]);
  wire  [2:0]  sy_idx   = sy_index(instr_r[5:4]);
  wire  [39:0] sx_val   = rf_r[sx_idx];
  wire  [39:0] sy_val   = rf_r[sy_idx];
  wire         use_y    = dec_y | abs_y | rnd_y;
  wire  [39:0] src1     = use_y ? sy_val : sx_val;
  wire  [3:0]  zc       = instr_r[3:0];
  wire  [2:0]  dz_idx   = (zc == 4'h5) ? 3'd0 : (zc == 4'h7) ? 3'd1 :
                          (zc == 4'hC) ? 3'd2 : (zc == 4'hE) ? 3'd3 :
                          (zc == 4'h8) ? 3'd4 : (zc == 4'h9) ? 3'd5 :
                          (zc == 4'hA) ? 3'd6 : 3'd7;
  wire         dz_ok    = (zc == 4'h5) | (zc == 4'h7) | (zc == 4'hC) | (zc == 4'hE)
                        | (zc[3:2] == 2'b10);
  wire  [39:0] dz_val   = rf_r[dz_idx];

  // Shift paths
  wire         shl      = ~imm[6];
  wire  [6:0]  amt      = shl ? imm : 7'(-imm);
  wire  [40:0] asl_w    = {1'b0, dz_val} << amt;
  wire  [40:0] asr_w    = 41'($signed({dz_val, 1'b0}) >>> amt);
  wire  [32:0] lsl_w    = {1'b0, dz_val[31:0]} << amt;
  wire  [32:0] lsr_w    = {dz_val[31:0], 1'b0} >> amt;

  // Arithmetic paths
  wire  [23:0] dec_xw   = sx_val[39:16] - 24'h000001;
  wire  [15:0] dec_yw   = sy_val[31:16] - 16'h0001;
  wire  [40:0] addc_w   = add41(sx_val, sy_val, condition_flag_r);
  wire  [40:0] subc_w   = sub41(sx_val, sy_val, condition_flag_r);
  wire  [40:0] cmp_w    = sub41(sx_val, sy_val, 1'b0);
  wire  [40:0] neg_w    = sub41(40'h0000000000, src1, 1'b0);
  wire  [40:0] rnd_w    = add41(src1, `RND_CONST, 1'b0);

  flag_req_t   req;
  logic        go;
  logic        wr_dz;
  logic        wr_hi;
  logic        wr_lo;
  logic        upd_flag;
  logic        force_flag;
  logic        flag_forced;
  logic        flag_mode;

  always_comb begin
    req         = '{mode: mode_r, cls: CL_ARITH, res: 40'h0000000000, carry: 1'b0, ovf: 1'b0};
    go          = 1'b0;
    wr_dz       = 1'b0;
    wr_hi       = 1'b0;
    wr_lo       = 1'b0;
    upd_flag    = 1'b0;
    force_flag  = 1'b0;
    flag_forced = 1'b0;
    unique case (op)
      OP_DEC: begin
        go        = go_cnd;
        req.res   = dec_y ? {{8{dec_yw[15]}}, dec_yw, 16'h0000} : {dec_xw, 16'h0000}; // RULE3
        req.carry = dec_y ? (sy_val[31:16] == 16'h0000) : (sx_val[39:16] == 24'h000000);
        req.ovf   = range_err(req.res);
        wr_dz     = go;
        upd_flag  = go & is_uncnd;
      end
      OP_CLR: begin
        go       = go_cnd;
        req.res  = `CLR_VALUE; // RULE4
        wr_dz    = go;
        upd_flag = go & is_uncnd;
      end
      OP_ASH: begin
        go        = 1'b1;
        req.cls   = CL_ASHIFT;
        req.res   = shl ? asl_w[39:0] : asr_w[40:1]; // RULE5
        req.carry = (amt == 7'h00) ? 1'b0 : (shl ? asl_w[40] : asr_w[0]);
        req.ovf   = range_err(req.res) | (shl & (req.res[39] != dz_val[39]));
        wr_dz     = 1'b1;
        upd_flag  = 1'b1;
      end
      OP_LSH: begin
        go        = 1'b1;
        req.cls   = CL_LSHIFT;
        req.res   = {8'h00, (shl ? lsl_w[31:0] : lsr_w[32:1])}; // RULE6
        req.carry = (amt == 7'h00) ? 1'b0 : (shl ? lsl_w[32] : lsr_w[0]);
        wr_dz     = 1'b1;
        upd_flag  = 1'b1;
      end
      OP_STS: begin
        go      = go_cnd;
        req.res = sts_h ? {{8{accum_high_reg_r[31]}}, accum_high_reg_r}
                        : {{8{accum_low_reg_r[31]}}, accum_low_reg_r}; // RULE7
        wr_dz   = go;
      end
      OP_LDS: begin
        go    = go_cnd;
        wr_hi = go & lds_h; // RULE8
        wr_lo = go & lds_l;
      end
      OP_ADDC: begin
        go          = 1'b1;
        req.res     = addc_w[39:0]; // RULE9
        wr_dz       = 1'b1;
        force_flag  = 1'b1;
        flag_forced = addc_w[40];
      end
      OP_SUBC: begin
        go          = 1'b1;
        req.res     = subc_w[39:0]; // RULE10
        wr_dz       = 1'b1;
        force_flag  = 1'b1;
        flag_forced = subc_w[40];
      end
      OP_CMP: begin
        go        = 1'b1;
        req.res   = cmp_w[39:0]; // RULE11
        req.carry = cmp_w[40];
        req.ovf   = range_err(req.res);
        upd_flag  = 1'b1;
      end
      OP_ABS: begin
        go        = src1[39]; // RULE12
        req.res   = neg_w[39:0];
        req.carry = neg_w[40];
        req.ovf   = range_err(req.res);
        wr_dz     = go;
        upd_flag  = go;
      end
      OP_RND: begin
        go        = 1'b1;
        req.res   = {rnd_w[39:16], 16'h0000}; // RULE13
        req.carry = rnd_w[40];
        req.ovf   = range_err(req.res);
        wr_dz     = 1'b1;
        upd_flag  = 1'b1;
      end
      default: begin
        go = 1'b0;
      end
    endcase
  end

  flag_update u_flag (
    .req      (req),
    .flag_cur (condition_flag_r),
    .flag_new (flag_mode)
  );

  wire         ex_go     = exec_r & go;
  wire         ex_dz     = ex_go & wr_dz & dz_ok;
  wire         ex_flag   = ex_go & (upd_flag | force_flag); // RULE22
  wire         flag_nxt  = force_flag ? flag_forced : flag_mode;
  wire  [39:0] dz_nxt    = fit(dz_idx, req.res);
  wire         ex_ill    = exec_r & ((op == OP_NONE) | ((wr_dz | op == OP_LDS) & ~dz_ok));

  // APB decode
  wire         setup     = psel & ~penable;
  wire         acc_wr    = psel & penable & pwrite & pready_r;
  wire         hit_rf    = (paddr >= `OFF_RF_BASE) && (paddr <= `OFF_RF_LAST) &&
                           (paddr[1:0] == 2'b00);
  wire  [2:0]  rf_sel    = paddr[4:2];
  wire         hit_fix   = (paddr == `OFF_CTRL) || (paddr == `OFF_INSTR) ||
                           (paddr == `OFF_STATUS) || (paddr == `OFF_ACC_HI) ||
                           (paddr == `OFF_ACC_LO) || (paddr == `OFF_GUARD_A0) ||
                           (paddr == `OFF_GUARD_A1);
  wire         hit       = hit_rf | hit_fix;
  wire  [31:0] wmask     = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire  [31:0] rd_data   =
      hit_rf                       ? rf_r[rf_sel][31:0] :
      (paddr == `OFF_CTRL)         ? {28'h0000000, mode_r, condition_flag_r} :
      (paddr == `OFF_INSTR)        ? instr_r :
      (paddr == `OFF_STATUS)       ? {30'h0000000, done_r, ill_r} :
      (paddr == `OFF_ACC_HI)       ? accum_high_reg_r :
      (paddr == `OFF_ACC_LO)       ? accum_low_reg_r :
      (paddr == `OFF_GUARD_A0)     ? {24'h000000, rf_r[0][39:32]} :
      (paddr == `OFF_GUARD_A1)     ? {24'h000000, rf_r[1][39:32]} : 32'h00000000;
  wire  [31:0] rf_low_w  = (rf_r[rf_sel][31:0] & ~wmask) | (pwdata & wmask);
  wire  [31:0] ctrl_w    = ({28'h0000000, mode_r, condition_flag_r} & ~wmask) | (pwdata & wmask);
  wire  [31:0] acch_w    = (accum_high_reg_r & ~wmask) | (pwdata & wmask);
  wire  [31:0] accl_w    = (accum_low_reg_r & ~wmask) | (pwdata & wmask);
  wire         wr_rf     = acc_wr & hit_rf;
  wire         wr_ctrl   = acc_wr & (paddr == `OFF_CTRL);
  wire         wr_instr  = acc_wr & (paddr == `OFF_INSTR);

  // Bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      prdata_r  <= (setup & ~pwrite) ? rd_data : 32'h00000000;
      pslverr_r <= setup & ~hit;
    end
  end

  // Instruction issue
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_r <= 32'h00000000;
      exec_r  <= 1'b0;
    end else begin
      exec_r <= wr_instr;
      if (wr_instr) begin
        instr_r <= pwdata;
      end
    end
  end

  // Transfer field issued regardless of the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_valid_r <= 1'b0;
      xfer_field_r <= 10'h000;
    end else begin
      xfer_valid_r <= exec_r & pfx_ok; // RULE21
      xfer_field_r <= exec_r ? instr_r[`XFER_HI:`XFER_LO] : xfer_field_r;
    end
  end

  // Status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ill_r  <= 1'b0;
      done_r <= 1'b0;
    end else if (exec_r) begin
      ill_r  <= ex_ill;
      done_r <= 1'b1;
    end else if (wr_instr) begin
      done_r <= 1'b0;
    end
  end

  // Condition flag and mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      condition_flag_r <= 1'b0;
      mode_r           <= `MODE_CARRY;
    end else if (ex_flag) begin
      condition_flag_r <= flag_nxt;
    end else if (wr_ctrl) begin
      condition_flag_r <= ctrl_w[`CTRL_FLAG_BIT];
      mode_r           <= ctrl_w[`CTRL_MODE_HI:`CTRL_MODE_LO];
    end
  end

  // Accumulators
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accum_high_reg_r <= 32'h00000000;
      accum_low_reg_r  <= 32'h00000000;
    end else begin
      if (exec_r & wr_hi & dz_ok) accum_high_reg_r <= dz_val[31:0];
      else if (acc_wr & (paddr == `OFF_ACC_HI)) accum_high_reg_r <= acch_w;
      if (exec_r & wr_lo & dz_ok) accum_low_reg_r <= dz_val[31:0];
      else if (acc_wr & (paddr == `OFF_ACC_LO)) accum_low_reg_r <= accl_w;
    end
  end

  // Data register file
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) rf_r[i] <= 40'h0000000000;
    end else if (ex_dz) begin
      rf_r[dz_idx] <= dz_nxt;
    end else if (wr_rf) begin
      rf_r[rf_sel] <= (rf_sel < 3'd2) ? {rf_r[rf_sel][39:32], rf_low_w}
                                      : {{8{rf_low_w[31]}}, rf_low_w};
    end else if (acc_wr & (paddr == `OFF_GUARD_A0) & pstrb[0]) begin
      rf_r[0][39:32] <= pwdata[7:0];
    end else if (acc_wr & (paddr == `OFF_GUARD_A1) & pstrb[0]) begin
      rf_r[1][39:32] <= pwdata[7:0];
    end
  end

  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign xfer_valid = xfer_valid_r;
  assign xfer_field = xfer_field_r;

endmodule : dsp_alu
`default_nettype wire

//--- logic/dsp_alu_pkg.sv
`default_nettype none
package dsp_alu_pkg;

  typedef enum logic [1:0] {
    CL_ARITH,
    CL_LOGIC,
    CL_ASHIFT,
    CL_LSHIFT
  } cls_t;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_DEC,
    OP_CLR,
    OP_ASH,
    OP_LSH,
    OP_STS,
    OP_LDS,
    OP_ADDC,
    OP_SUBC,
    OP_CMP,
    OP_ABS,
    OP_RND
  } op_t;

  typedef struct packed {
    logic [2:0]  mode;
    cls_t        cls;
    logic [39:0] res;
    logic        carry;
    logic        ovf;
  } flag_req_t;

endpackage : dsp_alu_pkg
`default_nettype wire

//--- logic/dsp_alu_regs.svh
`ifndef DSP_ALU_REGS_SVH
`define DSP_ALU_REGS_SVH

// Register byte offsets
`define OFF_CTRL      12'h000
`define OFF_INSTR     12'h004
`define OFF_STATUS    12'h008
`define OFF_ACC_HI    12'h00C
`define OFF_ACC_LO    12'h010
`define OFF_GUARD_A0  12'h014
`define OFF_GUARD_A1  12'h018
`define OFF_RF_BASE   12'h020
`define OFF_RF_LAST   12'h03C

// Control register fields
`define CTRL_FLAG_BIT 0
`define CTRL_MODE_HI  3
`define CTRL_MODE_LO  1

// Status register fields
`define STAT_ILL_BIT  0
`define STAT_DONE_BIT 1

// Instruction word layout
`define PFX_HI        31
`define PFX_LO        26
`define PFX_CODE      6'b111110
`define XFER_HI       25
`define XFER_LO       16

// Condition flag update modes
`define MODE_CARRY    3'b000
`define MODE_NEG      3'b001
`define MODE_ZERO     3'b010
`define MODE_OVF      3'b011
`define MODE_SGT      3'b100
`define MODE_SGE      3'b101

// Condition suffix of the operation byte
`define CND_ALWAYS    2'b01
`define CND_TRUE      2'b10
`define CND_FALSE     2'b11
`define CND_NONE      2'b00

// Operation byte groups (bits 15:10), shift codes (bits 15:11) and full bytes
`define GRP_DEC_X     6'b100010
`define GRP_DEC_Y     6'b101010
`define GRP_CLR       6'b100011
`define GRP_STS_H     6'b110011
`define GRP_STS_L     6'b110111
`define GRP_LDS_H     6'b111011
`define GRP_LDS_L     6'b111111
`define SHF_ARITH     5'b00010
`define SHF_LOGIC     5'b00000
`define OPB_ADDC      8'hB0
`define OPB_SUBC      8'hA0
`define OPB_CMP       8'h84
`define OPB_ABS_X     8'h88
`define OPB_ABS_Y     8'hA8
`define OPB_RND_X     8'h98
`define OPB_RND_Y     8'hB8

// Constants of the datapath
`define RND_CONST     40'h0000008000
`define CLR_VALUE     40'h0000000000

`endif

//--- logic/flag_update.sv
`default_nettype none
`include "dsp_alu_regs.svh"
module flag_update
  import dsp_alu_pkg::*;
(
  input  wire dsp_alu_pkg::flag_req_t req,
  input  wire logic                   flag_cur,
  output logic                        flag_new
);

  wire is_logic = (req.cls == CL_LOGIC) || (req.cls == CL_LSHIFT);
  wire neg_full = req.res[39];
  wire neg_low  = req.res[31];
  wire neg_sel  = is_logic ? neg_low : neg_full;
  wire zero     = is_logic ? (req.res[31:0] == 32'h00000000) : (req.res == 40'h0000000000);
  wire ovf      = req.ovf;

  always_comb begin
    unique case (req.mode)
      `MODE_CARRY: flag_new = (req.cls == CL_LOGIC) ? 1'b0 : req.carry; // RULE14
      `MODE_NEG:   flag_new = neg_sel;                                   // RULE15 RULE16
      `MODE_ZERO:  flag_new = zero;                                      // RULE17
      `MODE_OVF:   flag_new = is_logic ? 1'b0 : ovf;                     // RULE18
      `MODE_SGT:   flag_new = is_logic ? 1'b0 : ~((neg_full ^ ovf) | zero); // RULE19
      `MODE_SGE:   flag_new = is_logic ? 1'b0 : (ovf ? neg_full : ~neg_full); // RULE20
      default:     flag_new = flag_cur;                                  // RULE23
    endcase
  end

endmodule : flag_update
`default_nettype wire

//--- test/dsp_alu_properties.sv
`default_nettype none
`include "dsp_alu_regs.svh"
module dsp_alu_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        xfer_valid,
  input wire logic [9:0]  xfer_field
);
  wire logic [9:0] wr_field = pwdata[25:16];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Completed write of an instruction word
  sequence s_instr_wr;
    psel && penable && pready && pwrite && paddr == `OFF_INSTR;
  endsequence
  sequence s_good_pfx;
    pwdata[31:26] == `PFX_CODE;
  endsequence
  a_ready_access: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  a_ready_idle: assert property (!(psel && penable) |-> !pready)
    else $error("pready outside access cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  a_unmapped_err: assert property (psel && !penable && paddr == 12'h01C |=> pslverr)
    else $error("unmapped access not refused");
  a_xfer_issue: assert property (s_instr_wr ##0 s_good_pfx |-> ##2 xfer_valid)
    else $error("transfer not issued");
  a_xfer_field: assert property (s_instr_wr ##0 s_good_pfx |-> ##2 xfer_field == $past(wr_field, 2))
    else $error("transfer field wrong");
  a_xfer_badpfx: assert property (s_instr_wr ##0 pwdata[31:26] != `PFX_CODE |-> ##2 !xfer_valid)
    else $error("transfer issued for bad prefix");
  a_xfer_pulse: assert property (xfer_valid |=> !xfer_valid)
    else $error("transfer pulse too long");
endmodule : dsp_alu_properties
bind dsp_alu dsp_alu_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .xfer_valid(xfer_valid),
  .xfer_field(xfer_field));
`default_nettype wire

//--- test/tb.sv
`default_nettype none
`include "dsp_alu_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [3:0]  pstrb;
  logic        pready, pslverr, er;
  logic        xv;
  logic [9:0]  xf;
  int          error_cnt = 0;
  int          checks = 0;
  dsp_alu u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .xfer_valid(xv), .xfer_field(xf));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic wrap_up;
    if (error_cnt == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, d);
  endtask : rd
  task automatic ex(input logic [15:0] op);
    apb(1'b1, `OFF_INSTR, {6'b111110, 10'h2A5, op});
    repeat (2) @(posedge pclk);
    chk("xfer_valid", 32'h1, {31'h0, xv});
    chk("xfer_field", 32'h2A5, {22'h0, xf});
  endtask : ex
  // Preset flag, mode and sources, run one op, check X1 and flag
  task automatic row(input logic [3:0] c, input logic [31:0] x0, y0, x1,
                     input logic [15:0] op, input logic [31:0] e1, input logic [3:0] ec);
    apb(1'b1, `OFF_CTRL, {28'h0, c});
    apb(1'b1, 12'h030, x0);
    apb(1'b1, 12'h038, y0);
    apb(1'b1, 12'h034, x1);
    ex(op);
    rd(12'h034, e1, "x1");
    rd(`OFF_CTRL, {28'h0, ec}, "ctrl");
  endtask : row
  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFF_CTRL, 32'h0, "ctrl reset");
    rd(`OFF_ACC_HI, 32'h0, "acc_hi reset");
    apb(1'b0, 12'h01C, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    row(4'hC, 32'h30000, 32'h0, 32'h0, 16'h8909, 32'h20000, 4'hC);
    row(4'hC, 32'h0, 32'h0, 32'h55, 16'h8D09, 32'h0, 4'hC);
    row(4'hC, 32'h0, 32'h0, 32'h55, 16'h8E09, 32'h55, 4'hC);
    row(4'hD, 32'h0, 32'h0, 32'h55, 16'h8E09, 32'h0, 4'hD);
    row(4'hD, 32'h0, 32'h0, 32'h55, 16'h8F09, 32'h55, 4'hD);
    row(4'hC, 32'h0, 32'h0, 32'h55, 16'h8F09, 32'h0, 4'hC);
    row(4'h4, 32'h0, 32'h0, 32'h55, 16'h8F09, 32'h0, 4'h4);
    row(4'h4, 32'h0, 32'h0, 32'h55, 16'h8D09, 32'h0, 4'h5);
    row(4'hD, 32'h0, 32'h0, 32'h55, 16'h8D09, 32'h0, 4'hD);
    row(4'hC, 32'h0, 32'h0, 32'h10, 16'h1049, 32'h100, 4'hC);
    row(4'hC, 32'h0, 32'h0, 32'h80000000, 16'h17C9, 32'hF8000000, 4'hC);
    row(4'hC, 32'h0, 32'h0, 32'h80000000, 16'h07C9, 32'h8000000, 4'hC);
    row(4'h0, 32'h0, 32'h0, 32'h80000000, 16'h0019, 32'h0, 4'h1);
    row(4'h2, 32'h0, 32'h0, 32'h40000000, 16'h0019, 32'h80000000, 4'h3);
    row(4'h1, 32'h7FFFFFFF, 32'h1, 32'h0, 16'hB009, 32'h80000001, 4'h0);
    row(4'h1, 32'h5, 32'h3, 32'h0, 16'hA009, 32'h1, 4'h0);
    row(4'h0, 32'h3, 32'h5, 32'h0, 16'hA009, 32'hFFFFFFFE, 4'h1);
    row(4'h2, 32'h3, 32'h5, 32'h55, 16'h8400, 32'h55, 4'h3);
    row(4'h8, 32'h5, 32'h3, 32'h55, 16'h8400, 32'h55, 4'h9);
    row(4'h9, 32'h3, 32'h3, 32'h55, 16'h8400, 32'h55, 4'h8);
    row(4'hA, 32'h3, 32'h3, 32'h55, 16'h8400, 32'h55, 4'hB);
    row(4'h6, 32'h7FFFFFFF, 32'hFFFFFFFF, 32'h55, 16'h8400, 32'h55, 4'h7);
    row(4'hC, 32'hFFFFFFFB, 32'h0, 32'h0, 16'h8809, 32'h5, 4'hC);
    row(4'hC, 32'h7, 32'h0, 32'h55, 16'h8809, 32'h55, 4'hC);
    row(4'hC, 32'h18000, 32'h0, 32'h0, 16'h9809, 32'h20000, 4'hC);
    apb(1'b1, `OFF_ACC_HI, 32'h12345678);
    row(4'h3, 32'h0, 32'h0, 32'h0, 16'hCD09, 32'h12345678, 4'h3);
    row(4'h3, 32'h1357, 32'h0, 32'h55, 16'hFD08, 32'h55, 4'h3);
    rd(`OFF_ACC_LO, 32'h1357, "acc_lo");
    row(4'h3, 32'h0, 32'h0, 32'h40000000, 16'h1019, 32'h80000000, 4'h2);
    row(4'hC, 32'h0, 32'h30000, 32'h55, 16'hA909, 32'h20000, 4'hC);
    row(4'hC, 32'h0, 32'hFFFFFFFB, 32'h55, 16'hA809, 32'h5, 4'hC);
    row(4'hC, 32'h0, 32'h18000, 32'h55, 16'hB809, 32'h20000, 4'hC);
    row(4'h5, 32'h0, 32'h0, 32'h55, 16'hDE09, 32'h1357, 4'h5);
    row(4'h0, 32'h2468, 32'h0, 32'h55, 16'hEF08, 32'h55, 4'h0);
    rd(`OFF_ACC_HI, 32'h2468, "acc_hi");
    apb(1'b1, `OFF_INSTR, 32'h00008D09);
    @(posedge pclk);
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk("illegal", 32'h1, {31'h0, d[0]});
    wrap_up();
  end
endmodule : tb
`default_nettype wire
